// >>> core/eeprom_params.svh
// Constants shared by both ends of the serial memory link: opcodes, field sizes and timing.
// Assumes a 100 MHz system clock on both ends.
`ifndef EEPROM_PARAMS_SVH
`define EEPROM_PARAMS_SVH

// System clock period in nanoseconds.
`define CLK_PERIOD_NS 10

// Longest self-timed erase/write cycle, and its length in whole clock cycles (rounded down).
`define EW_TIME_NS 10000000
`define EW_CYCLES (`EW_TIME_NS / `CLK_PERIOD_NS)

// Half period of the serial clock made by the controller, at least the minimum high/low time.
`define SCLK_HALF_NS 2000
`define SCLK_HALF_CYCLES ((`SCLK_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Opcodes; the word program opcode ignores its leading bit.
`define OPC_READ 4'h8
`define OPC_PROG_LOW 3'h4
`define OPC_PROG 4'h4
`define OPC_PROG_EN 4'h3
`define OPC_PROG_DIS 4'h0
`define OPC_ERASE_ALL 4'h2
`define OPC_WRITE_ALL 4'h1

// Instruction layout for the wide (64x16) and narrow (128x8) organisations.
`define HDR_WIDE 5'h0b
`define HDR_NARROW 5'h0c
`define DBITS_WIDE 5'h10
`define DBITS_NARROW 5'h08
`define WORDS 64
`define ERASED_WORD 16'hffff

`endif

// >>> core/eeprom_pkg.sv
// Types shared by the memory end and the controller end of the serial link.
// Assumes nothing beyond the constants header.
package eeprom_pkg;

    // Memory end: command shifting and self-timed cycle states.
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_HDR  = 3'b001,
        S_DATA = 3'b010,
        S_READ = 3'b011,
        S_BUSY = 3'b100,
        S_DONE = 3'b101
    } dev_state_e;

    // Memory end: kind of self-timed job pending.
    typedef enum logic [1:0] {
        JOB_PROG      = 2'b00,
        JOB_ERASE_ALL = 2'b01,
        JOB_WRITE_ALL = 2'b10
    } dev_job_e;

    // Controller end: states of the bit sequencer.
    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_LOW  = 3'b001,
        H_HIGH = 3'b010,
        H_GAP  = 3'b011,
        H_POLL = 3'b100
    } host_state_e;

    // Controller end: operations the user may request.
    typedef enum logic [2:0] {
        HOP_READ      = 3'b000,
        HOP_PROG      = 3'b001,
        HOP_PROG_EN   = 3'b010,
        HOP_PROG_DIS  = 3'b011,
        HOP_ERASE_ALL = 3'b100,
        HOP_WRITE_ALL = 3'b101
    } host_op_e;

endpackage

// >>> core/eeprom_link_if.sv
// Pin-level link between the serial memory and its controller.
// The serial output is three-state; an undriven line reads as zero here.
`timescale 1ns/1ps

interface eeprom_link_if;
    logic cs;
    logic sclk;
    logic serial_in;
    logic serial_out;
    logic serial_out_oe_n;
    logic ready;
    logic serial_out_seen;

    // Level the controller sees on the three-state data line.
    assign serial_out_seen = ~serial_out_oe_n & serial_out;

    modport dev (
        input cs,
        input sclk,
        input serial_in,
        output serial_out,
        output serial_out_oe_n,
        output ready
    );

    modport host (
        output cs,
        output sclk,
        output serial_in,
        input serial_out_seen,
        input ready
    );
endinterface

// >>> core/eeprom_device.sv
// Serial memory end: command shifter, read-out, program protection and self-timed cycles.
// Assumes link pins are synchronous to mclk_in and the serial clock is far slower.
`timescale 1ns/1ps
`include "eeprom_params.svh"

module eeprom_device
    import eeprom_pkg::*;
#(
    parameter int unsigned EW_CYCLES = `EW_CYCLES
) (
    input wire logic mclk_in,              // System clock.
    input wire logic sys_rst_in,           // Synchronous reset, stands for power-up.
    input wire logic word_width_select_in, // High: 64x16, low: 128x8.
    eeprom_link_if.dev link                // Pins toward the controller.
);

    localparam int unsigned EW_W = $clog2(EW_CYCLES + 1);
    localparam int unsigned EW_HALF = EW_CYCLES / 2;

    // Last header bit index after the start bit.
    function automatic logic [4:0] hdr_last(input logic wide);
        hdr_last = wide ? (`HDR_WIDE - 5'h02) : (`HDR_NARROW - 5'h02);
    endfunction

    // Number of data bits in a word.
    function automatic logic [4:0] data_bits(input logic wide);
        data_bits = wide ? `DBITS_WIDE : `DBITS_NARROW;
    endfunction

    // Array word that holds an address.
    function automatic logic [5:0] word_idx(input logic [6:0] a, input logic wide);
        word_idx = wide ? a[5:0] : a[6:1];
    endfunction

    // Bits of the array word touched by an address; odd narrow addresses use the high byte.
    function automatic logic [15:0] lane_mask(input logic [6:0] a, input logic wide);
        lane_mask = wide ? 16'hffff : (a[0] ? 16'hff00 : 16'h00ff);
    endfunction

    // Write data spread over both byte lanes in the narrow layout.
    function automatic logic [15:0] lane_data(input logic [15:0] d, input logic wide);
        lane_data = wide ? d : {d[7:0], d[7:0]};
    endfunction

    logic [15:0] mem_q [0:`WORDS-1];
    dev_state_e st_q;
    dev_job_e job_q;
    logic sclk_q;
    logic wide_q;
    logic en_q;
    logic [10:0] hdr_q;
    logic [4:0] cnt_q;
    logic [6:0] addr_q;
    logic [15:0] dat_q;
    logic [15:0] rd_q;
    logic [EW_W-1:0] ew_q;
    logic serial_out_q;
    logic oe_n_q;
    logic ready_q;

    logic rise;
    logic [10:0] hdr_d;
    logic [3:0] op_w;
    logic [6:0] addr_w;
    logic hdr_done;
    logic data_done;
    logic go_busy;
    logic ew_mid;
    logic ew_end;
    logic [15:0] rd_word;
    logic [15:0] store_d;
    logic [15:0] mask_w;

    // Serial clock edge seen in the system clock domain, only while selected.
    assign rise = link.cs & link.sclk & ~sclk_q;

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            sclk_q <= 1'b0;
        end else begin
            sclk_q <= link.sclk;
        end
    end

    // Header fields taken from the shift register with the bit now arriving.
    always_comb begin
        hdr_d = {hdr_q[9:0], link.serial_in};
        op_w = wide_q ? hdr_d[9:6] : hdr_d[10:7];
        addr_w = wide_q ? {1'b0, hdr_d[5:0]} : hdr_d[6:0];
        hdr_done = rise && (st_q == S_HDR) && (cnt_q == hdr_last(wide_q));
        data_done = rise && (st_q == S_DATA) && (cnt_q == data_bits(wide_q) - 5'h01);
        go_busy = (hdr_done && (op_w == `OPC_ERASE_ALL) && en_q) || data_done;
        ew_mid = (st_q == S_BUSY) && (ew_q == EW_W'(EW_HALF));
        ew_end = (st_q == S_BUSY) && (ew_q == EW_W'(EW_CYCLES - 1));
        rd_word = mem_q[word_idx(addr_w, wide_q)];
        store_d = lane_data(dat_q, wide_q);
        mask_w = lane_mask(addr_q, wide_q);
    end

    // Command sequencer; a dropped chip select abandons everything but a running cycle.
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            st_q <= S_IDLE;
            job_q <= JOB_PROG;
            wide_q <= 1'b1;
            hdr_q <= 11'h000;
            cnt_q <= 5'h00;
            addr_q <= 7'h00;
            dat_q <= 16'h0000;
        end else begin
            case (st_q)
                S_IDLE: begin
                    if (rise && link.serial_in) begin
                        st_q <= S_HDR;
                        cnt_q <= 5'h00;
                        hdr_q <= 11'h000;
                        wide_q <= word_width_select_in;
                    end
                end
                S_HDR: begin
                    if (!link.cs) begin
                        st_q <= S_IDLE;
                    end else if (rise) begin
                        hdr_q <= hdr_d;
                        cnt_q <= cnt_q + 5'h01;
                        if (hdr_done) begin
                            addr_q <= addr_w;
                            cnt_q <= 5'h00;
                            // Protected commands fall through to S_DONE while disabled.
                            if (op_w == `OPC_READ) begin
                                st_q <= S_READ;
                            end else if (op_w[2:0] == `OPC_PROG_LOW && en_q) begin
                                st_q <= S_DATA;
                                job_q <= JOB_PROG;
                            end else if (op_w == `OPC_ERASE_ALL && en_q) begin
                                st_q <= S_BUSY;
                                job_q <= JOB_ERASE_ALL;
                            end else if (op_w == `OPC_WRITE_ALL && en_q) begin
                                st_q <= S_DATA;
                                job_q <= JOB_WRITE_ALL;
                            end else begin
                                st_q <= S_DONE;
                            end
                        end
                    end
                end
                S_DATA: begin
                    if (!link.cs) begin
                        st_q <= S_IDLE;
                    end else if (rise) begin
                        dat_q <= {dat_q[14:0], link.serial_in};
                        cnt_q <= cnt_q + 5'h01;
                        if (data_done) begin
                            st_q <= S_BUSY;
                        end
                    end
                end
                S_READ: begin
                    if (!link.cs) begin
                        st_q <= S_IDLE;
                    end else if (rise) begin
                        cnt_q <= cnt_q + 5'h01;
                        if (cnt_q == data_bits(wide_q)) begin
                            st_q <= S_DONE;
                        end
                    end
                end
                S_DONE: begin
                    if (!link.cs) begin
                        st_q <= S_IDLE;
                    end
                end
                S_BUSY: begin
                    // Chip select and serial clock are ignored until the cycle ends.
                    if (ew_end) begin
                        st_q <= S_IDLE;
                    end
                end
                default: begin
                    st_q <= S_IDLE;
                end
            endcase
        end
    end

    // Program enable latch; cleared only by reset or the disable command.
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            en_q <= 1'b0;
        end else if (hdr_done && op_w == `OPC_PROG_EN) begin
            en_q <= 1'b1;
        end else if (hdr_done && op_w == `OPC_PROG_DIS) begin
            en_q <= 1'b0;
        end
    end

    // Self-timed cycle counter, free of any serial clock edge.
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in || st_q != S_BUSY) begin
            ew_q <= '0;
        end else begin
            ew_q <= ew_q + EW_W'(1);
        end
    end

    // Ready pin: low from the accepting edge to the end of the cycle.
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            ready_q <= 1'b1;
        end else if (go_busy) begin
            ready_q <= 1'b0;
        end else if (ew_end) begin
            ready_q <= 1'b1;
        end
    end

    // Read-out shifter; the line is driven only between the read header and its end.
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            oe_n_q <= 1'b1;
            serial_out_q <= 1'b0;
            rd_q <= 16'h0000;
        end else if (hdr_done && op_w == `OPC_READ) begin
            oe_n_q <= 1'b0;
            serial_out_q <= 1'b0;
            if (wide_q) begin
                rd_q <= rd_word;
            end else begin
                rd_q <= addr_w[0] ? {rd_word[15:8], 8'h00} : {rd_word[7:0], 8'h00};
            end
        end else if (st_q != S_READ || !link.cs) begin
            oe_n_q <= 1'b1;
            serial_out_q <= 1'b0;
        end else if (rise && cnt_q == data_bits(wide_q)) begin
            oe_n_q <= 1'b1;
            serial_out_q <= 1'b0;
        end else if (rise) begin
            serial_out_q <= rd_q[15];
            rd_q <= {rd_q[14:0], 1'b0};
        end
    end

    // Array updates. Write-all only clears bits, so it needs an erased array first.
    always_ff @(posedge mclk_in) begin
        if (ew_mid && job_q == JOB_PROG) begin
            mem_q[word_idx(addr_q, wide_q)] <= mem_q[word_idx(addr_q, wide_q)] | mask_w;
        end else if (ew_end) begin
            for (int i = 0; i < `WORDS; i++) begin
                if (job_q == JOB_ERASE_ALL) begin
                    mem_q[i] <= `ERASED_WORD;
                end else if (job_q == JOB_WRITE_ALL) begin
                    mem_q[i] <= mem_q[i] & store_d;
                end else if (6'(i) == word_idx(addr_q, wide_q)) begin
                    mem_q[i] <= mem_q[i] & (store_d | ~mask_w);
                end
            end
        end
    end

    assign link.serial_out = serial_out_q;
    assign link.serial_out_oe_n = oe_n_q;
    assign link.ready = ready_q;

endmodule

// >>> core/eeprom_host.sv
// Controller end: turns one user request into a framed serial instruction and polls ready.
// Assumes the memory end samples on rising serial clock edges and shifts out on them.
`timescale 1ns/1ps
`include "eeprom_params.svh"

module eeprom_host
    import eeprom_pkg::*;
#(
    parameter int unsigned HALF_CYCLES = `SCLK_HALF_CYCLES
) (
    input wire logic mclk_in,         // System clock.
    input wire logic sys_rst_in,      // Synchronous reset.
    input wire logic start_in,        // Request pulse, taken while idle.
    input wire host_op_e op_in,       // Requested operation.
    input wire logic wide_in,         // Layout of the memory: high 64x16.
    input wire logic [6:0] addr_in,   // Word address.
    input wire logic [15:0] data_in,  // Write data, low 8 bits in narrow layout.
    output logic busy_out,            // Request in progress.
    output logic done_out,            // One-cycle completion pulse.
    output logic refused_out,         // With done_out: program op refused.
    output logic [15:0] rdata_out,    // Read data, low bits in narrow layout.
    eeprom_link_if.host link          // Pins toward the memory.
);

    localparam int unsigned HC_W = $clog2(HALF_CYCLES + 1);

    // Opcode sent for each user operation.
    function automatic logic [3:0] op_code(input host_op_e op);
        case (op)
            HOP_READ: op_code = `OPC_READ;
            HOP_PROG: op_code = `OPC_PROG;
            HOP_PROG_EN: op_code = `OPC_PROG_EN;
            HOP_PROG_DIS: op_code = `OPC_PROG_DIS;
            HOP_ERASE_ALL: op_code = `OPC_ERASE_ALL;
            default: op_code = `OPC_WRITE_ALL;
        endcase
    endfunction

    host_state_e st_q;
    host_op_e op_q;
    logic [HC_W-1:0] hc_q;
    logic [5:0] bit_q;
    logic [5:0] nbits_q;
    logic [27:0] tx_q;
    logic [15:0] rx_q;
    logic en_q;
    logic wide_q;
    logic cs_q;
    logic sclk_q;
    logic sin_q;
    logic busy_q;
    logic done_q;
    logic refused_q;
    logic [15:0] rdata_q;
    logic half_end;
    logic needs_en;
    logic [3:0] opc;
    logic [5:0] extra;

    always_comb begin
        half_end = (hc_q == HC_W'(HALF_CYCLES - 1));
        needs_en = (op_in == HOP_PROG) || (op_in == HOP_ERASE_ALL) || (op_in == HOP_WRITE_ALL);
        opc = op_code(op_in);
        extra = (op_in == HOP_READ || op_in == HOP_PROG || op_in == HOP_WRITE_ALL)
            ? (wide_in ? 6'h10 : 6'h08) : 6'h00;
    end

    // Bit sequencer: data set while the clock is low, read bits sampled at the fall.
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            st_q <= H_IDLE;
            op_q <= HOP_READ;
            hc_q <= '0;
            bit_q <= 6'h00;
            nbits_q <= 6'h00;
            tx_q <= 28'h0000000;
            rx_q <= 16'h0000;
            wide_q <= 1'b1;
            cs_q <= 1'b0;
            sclk_q <= 1'b0;
            sin_q <= 1'b0;
        end else begin
            hc_q <= half_end ? '0 : hc_q + HC_W'(1);
            case (st_q)
                H_IDLE: begin
                    hc_q <= '0;
                    // Programming ops are refused, not queued, until enable was sent.
                    if (start_in && !(needs_en && !en_q)) begin
                        st_q <= H_LOW;
                        op_q <= op_in;
                        wide_q <= wide_in;
                        bit_q <= 6'h00;
                        cs_q <= 1'b1;
                        sin_q <= 1'b1;
                        if (wide_in) begin
                            tx_q <= {1'b1, opc, addr_in[5:0], data_in, 1'b0};
                            nbits_q <= 6'(`HDR_WIDE) + extra;
                        end else begin
                            tx_q <= {1'b1, opc, addr_in, data_in[7:0], 8'h00};
                            nbits_q <= 6'(`HDR_NARROW) + extra;
                        end
                    end
                end
                H_LOW: begin
                    if (half_end) begin
                        st_q <= H_HIGH;
                        sclk_q <= 1'b1;
                    end
                end
                H_HIGH: begin
                    if (half_end) begin
                        sclk_q <= 1'b0;
                        rx_q <= {rx_q[14:0], link.serial_out_seen};
                        tx_q <= {tx_q[26:0], 1'b0};
                        sin_q <= tx_q[26];
                        bit_q <= bit_q + 6'h01;
                        if (bit_q == nbits_q - 6'h01) begin
                            st_q <= H_GAP;
                            cs_q <= 1'b0;
                            sin_q <= 1'b0;
                        end else begin
                            st_q <= H_LOW;
                        end
                    end
                end
                H_GAP: begin
                    if (half_end) begin
                        st_q <= (op_q == HOP_PROG || op_q == HOP_ERASE_ALL ||
                            op_q == HOP_WRITE_ALL) ? H_POLL : H_IDLE;
                    end
                end
                H_POLL: begin
                    if (link.ready) begin
                        st_q <= H_IDLE;
                    end
                end
                default: begin
                    st_q <= H_IDLE;
                end
            endcase
        end
    end

    // Own copy of the memory's enable state, following the commands sent.
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            en_q <= 1'b0;
        end else if (st_q == H_GAP && half_end && op_q == HOP_PROG_EN) begin
            en_q <= 1'b1;
        end else if (st_q == H_GAP && half_end && op_q == HOP_PROG_DIS) begin
            en_q <= 1'b0;
        end
    end

    // User-side answer flops.
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
            refused_q <= 1'b0;
            rdata_q <= 16'h0000;
        end else begin
            done_q <= 1'b0;
            refused_q <= 1'b0;
            if (st_q == H_IDLE && start_in) begin
                busy_q <= !(needs_en && !en_q);
                done_q <= needs_en && !en_q;
                refused_q <= needs_en && !en_q;
            end else if ((st_q == H_GAP && half_end && op_q != HOP_PROG &&
                op_q != HOP_ERASE_ALL && op_q != HOP_WRITE_ALL) ||
                (st_q == H_POLL && link.ready)) begin
                busy_q <= 1'b0;
                done_q <= 1'b1;
                if (op_q == HOP_READ) begin
                    rdata_q <= wide_q ? rx_q : {8'h00, rx_q[7:0]};
                end
            end
        end
    end

    assign link.cs = cs_q;
    assign link.sclk = sclk_q;
    assign link.serial_in = sin_q;
    assign busy_out = busy_q;
    assign done_out = done_q;
    assign refused_out = refused_q;
    assign rdata_out = rdata_q;

endmodule

// >>> testbench/eeprom_link_sva.sv
// Checker of the link pins between the two ends of the serial memory.
// Assumes every link signal changes only on mclk_in edges.
`timescale 1ns/1ps
`include "eeprom_params.svh"

module eeprom_link_sva #(
    parameter int unsigned EW_CYCLES = `EW_CYCLES
) (
    input wire logic mclk_in, // System clock.
    input wire logic sys_rst_in, // Synchronous reset.
    input wire logic cs, // Chip select.
    input wire logic sclk, // Serial clock.
    input wire logic serial_out, // Memory data out.
    input wire logic serial_out_oe_n, // Low while memory drives.
    input wire logic ready // High ready, low busy.
);
    logic [31:0] low_q;

    default clocking @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);

    // Busy cycles are counted, since a long repetition would stall the tools.
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in || ready) begin
            low_q <= 32'h0;
        end else begin
            low_q <= low_q + 32'h1;
        end
    end

    chk_oe_needs_cs: assert property (!serial_out_oe_n |-> $past(cs))
        else $error("data line driven without chip select");
    chk_quiet_busy: assert property (!ready |-> serial_out_oe_n)
        else $error("data line driven while busy");
    chk_oe_release: assert property ($rose(serial_out_oe_n) |-> !$past(cs) || $past(sclk))
        else $error("data line released without cause");
    chk_dummy_zero: assert property ($fell(serial_out_oe_n) |-> !serial_out)
        else $error("first read bit is not zero");
    chk_bit_on_rise: assert property (!serial_out_oe_n && $changed(serial_out)
        |-> $past(sclk) && !$past(sclk, 2))
        else $error("read bit changed away from a serial clock rise");
    chk_busy_cause: assert property ($fell(ready) |-> $past(cs) && $past(sclk))
        else $error("busy began without a received bit");
    chk_busy_length: assert property ($rose(ready) |-> low_q == EW_CYCLES)
        else $error("self-timed cycle has the wrong length");
    chk_busy_bound: assert property (!ready |-> low_q < EW_CYCLES)
        else $error("self-timed cycle overran");
endmodule

// >>> testbench/tb_serial_eeprom_command_port.sv
// Bench joining the controller end to the memory end over one link.
// Assumes shortened serial and self-timed counts so the run stays short.
`timescale 1ns/1ps
`include "eeprom_params.svh"
`define CHK(nm, e, s) begin checks++; if ((s) !== (e)) begin error_cnt++; \
    $display("wrong value %s expected %h seen %h", nm, e, s); end end

module tb_serial_eeprom_command_port
    import eeprom_pkg::*;
;
    logic mclk_in = 0;
    logic sys_rst_in = 1;
    logic start = 0;
    logic wide = 1;
    host_op_e op = HOP_READ;
    logic [6:0] addr = 7'h0;
    logic [15:0] wdata = 16'h0;
    logic done;
    logic busy;
    logic refused;
    logic [15:0] rdata;
    logic sclk_d = 0;
    logic [31:0] frame = 32'h0;
    int nbits = 0;
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;

    eeprom_link_if eeprom_link_if_inst ();
    eeprom_device #(.EW_CYCLES(40)) eeprom_device_inst (.mclk_in(mclk_in),
        .sys_rst_in(sys_rst_in), .word_width_select_in(wide), .link(eeprom_link_if_inst));
    eeprom_host #(.HALF_CYCLES(4)) eeprom_host_inst (.mclk_in(mclk_in),
        .sys_rst_in(sys_rst_in), .start_in(start), .op_in(op), .wide_in(wide),
        .addr_in(addr), .data_in(wdata), .busy_out(busy), .done_out(done),
        .refused_out(refused), .rdata_out(rdata), .link(eeprom_link_if_inst));
    eeprom_link_sva #(.EW_CYCLES(40)) eeprom_link_sva_inst (.mclk_in(mclk_in),
        .sys_rst_in(sys_rst_in), .cs(eeprom_link_if_inst.cs), .sclk(eeprom_link_if_inst.sclk),
        .serial_out(eeprom_link_if_inst.serial_out),
        .serial_out_oe_n(eeprom_link_if_inst.serial_out_oe_n),
        .ready(eeprom_link_if_inst.ready));

    // Free-running system clock.
    initial begin
        forever #5 mclk_in = ~mclk_in;
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Records each bit the memory samples, so the wire is judged apart from the host.
    always @(posedge mclk_in) begin
        sclk_d <= eeprom_link_if_inst.sclk;
        cyc <= cyc + 1;
        if (eeprom_link_if_inst.cs && eeprom_link_if_inst.sclk && !sclk_d) begin
            frame <= {frame[30:0], eeprom_link_if_inst.serial_in};
            nbits <= nbits + 1;
        end
        if (cyc == 20000) begin
            error_cnt++;
            stop_test();
        end
    end

    // One request through the host; the expected frame is built from the opcode.
    task automatic op_run(input host_op_e o, input logic [3:0] opc, input logic [6:0] a,
            input logic [15:0] d, input logic x_ref, input logic [15:0] x_rd);
        int aw;
        int dw;
        int fb;
        int nb;
        logic [31:0] f;
        aw = wide ? 6 : 7;
        dw = wide ? 16 : 8;
        f = ({28'h1, opc} << aw) | 32'(a);
        fb = 5 + aw;
        nb = (o == HOP_READ) ? fb + dw : fb;
        if (o == HOP_PROG || o == HOP_WRITE_ALL) begin
            f = (f << dw) | 32'(d);
            fb = fb + dw;
            nb = fb;
        end
        @(posedge mclk_in);
        #1 nbits = 0;
        op = o;
        addr = a;
        wdata = d;
        start = 1;
        @(posedge mclk_in);
        #1 start = 0;
        `CHK("busy at start", !x_ref, busy)
        repeat (3000) begin
            if (done === 1'b1) break;
            @(posedge mclk_in);
            #1;
        end
        `CHK("busy at done", 1'b0, busy)
        `CHK("refused", x_ref, refused)
        `CHK("ready", 1'b1, eeprom_link_if_inst.ready)
        `CHK("bit count", x_ref ? 0 : nb, nbits)
        if (!x_ref) `CHK("frame", f, (frame >> (nb - fb)) & ((32'h1 << fb) - 32'h1))
        if (o == HOP_READ) `CHK("read data", x_rd, rdata)
    endtask

    // Main sequence: protection, erase, program, write-all, then the narrow layout.
    initial begin
        repeat (3) @(posedge mclk_in);
        #1 sys_rst_in = 0;
        op_run(HOP_ERASE_ALL, `OPC_ERASE_ALL, 7'h0, 16'h0, 1, 16'h0);
        op_run(HOP_PROG_EN, `OPC_PROG_EN, 7'h0, 16'h0, 0, 16'h0);
        op_run(HOP_ERASE_ALL, `OPC_ERASE_ALL, 7'h0, 16'h0, 0, 16'h0);
        op_run(HOP_READ, `OPC_READ, 7'h05, 16'h0, 0, `ERASED_WORD);
        op_run(HOP_PROG, `OPC_PROG, 7'h05, 16'h1234, 0, 16'h0);
        op_run(HOP_PROG, `OPC_PROG, 7'h3f, 16'h8001, 0, 16'h0);
        op_run(HOP_PROG_DIS, `OPC_PROG_DIS, 7'h0, 16'h0, 0, 16'h0);
        op_run(HOP_PROG, `OPC_PROG, 7'h05, 16'h0, 1, 16'h0);
        op_run(HOP_READ, `OPC_READ, 7'h05, 16'h0, 0, 16'h1234);
        op_run(HOP_READ, `OPC_READ, 7'h3f, 16'h0, 0, 16'h8001);
        op_run(HOP_PROG_EN, `OPC_PROG_EN, 7'h0, 16'h0, 0, 16'h0);
        op_run(HOP_ERASE_ALL, `OPC_ERASE_ALL, 7'h0, 16'h0, 0, 16'h0);
        op_run(HOP_WRITE_ALL, `OPC_WRITE_ALL, 7'h0, 16'h0a5f, 0, 16'h0);
        op_run(HOP_READ, `OPC_READ, 7'h3f, 16'h0, 0, 16'h0a5f);
        wide = 0;
        op_run(HOP_READ, `OPC_READ, 7'h01, 16'h0, 0, 16'h000a);
        op_run(HOP_PROG, `OPC_PROG, 7'h7f, 16'h003c, 0, 16'h0);
        op_run(HOP_READ, `OPC_READ, 7'h7f, 16'h0, 0, 16'h003c);
        op_run(HOP_READ, `OPC_READ, 7'h7e, 16'h0, 0, 16'h005f);
        op_run(HOP_PROG_DIS, `OPC_PROG_DIS, 7'h0, 16'h0, 0, 16'h0);
        stop_test();
    end
endmodule
